// File: pkg/dacf_pkg.sv
// Operation
// - Sample the serial input on every shift-clock falling edge while selected.
// - Control bits shift in during the same cycles the result shifts out.
// - Act only on the third input bit from the MSB; ignore the rest.
// - Third bit 0 picks input zero, 1 input one, for the next conversion.
// - Drive each output bit on a falling edge, during the conversion itself; the code loads the first leading zero at the previous deselect.
// - Each frame carries one 16-bit output word.
// - 12-bit: two zeros, channel id, invalid id copy, 12 result bits MSB first.
// - 10-bit: two zeros, id, id copy, 10 result bits MSB first, two zeros.
// - Result code is unsigned straight binary, zero low, all ones full scale.
// - The shift clock alone paces conversion, readout and input capture.
// - Chip-select falling edge captures the selected input and starts conversion.
package dacf_pkg;
  localparam int          FRAME_BITS   = 16;       // output word length
  localparam int          CNT_W        = 5;        // frame edge counter width
  localparam int          RES_MAX      = 12;       // widest result
  localparam int          RES_MIN      = 10;       // narrow variant result
  localparam logic [4:0]  CHAN_IDX     = 5'h03;    // edge that samples the third input bit
  localparam logic [4:0]  IDENT_IDX    = 5'h02;    // word position of channel id
  localparam logic [4:0]  INVAL_IDX    = 5'h03;    // word position of invalid id copy
  localparam logic [4:0]  RESULT_IDX   = 5'h04;    // word position of result MSB
  localparam logic [4:0]  CNT_SAT      = 5'h10;    // counter stops at word end
  localparam logic [11:0] TRIAL_RESET  = 12'h800;  // first trial: midscale
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic        CHAN_RESET   = 1'b0;     // analog_input_zero after reset
  localparam int          SCLK_MAX_HZ  = 5000000;  // fastest shift clock
  localparam int          SYS_CLK_HZ   = 40000000;
endpackage

// File: verilog/dacf_sync.sv
`timescale 1ns/10ps
// two-stage level synchroniser
module dacf_sync (
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic din,
  output logic      dout
);
  logic stage1;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // dacf_sync

// File: verilog/dacf_frame.sv
`timescale 1ns/10ps
// serial frame, channel select and SAR sequencing for the two-channel converter
module dacf_frame (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // link side, timed by the host shift clock
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        din,
  output logic             sdoData,
  output logic             sdoEnN,
  // analog section
  input  wire logic        compHigh,
  output logic [11:0]      dacCode,
  output logic             muxSel,
  output logic             holdSample,
  // system side
  input  wire logic        wide12,
  output logic [11:0]      resultData,
  output logic             resultChan,
  output logic             resultValid
);
  import dacf_pkg::*;

  logic [CNT_W-1:0] bitCount;
  logic [CNT_W-1:0] edgeIdx;
  logic [11:0]      trial;
  logic [11:0]      result;
  logic             nextChan;
  logic             convChan;
  logic             wideLink;
  logic             doneToggle;
  logic             doneSync;
  logic             doneSeen;
  logic             sclkInv;
  logic             inResult;
  logic [3:0]       resPos;
  logic [3:0]       resBit;
  logic [4:0]       resEnd;
  logic             lastEdge;
  logic [11:0]      decided;
  logic [11:0]      heldData;
  logic             heldChan;

  // result word with one bit replaced by a fresh decision
  function automatic logic [11:0] withBit(input logic [11:0] word,
                                          input logic [3:0]  pos,
                                          input logic        val);
    logic [11:0] tmp;
    tmp      = word;
    tmp[pos] = val;
    return tmp;
  endfunction

  // word position inside a field that starts at first and stops before last
  function automatic logic inField(input logic [4:0] idx,
                                   input logic [4:0] first,
                                   input logic [4:0] last);
    return (idx >= first) && (idx < last);
  endfunction

  // falling-edge domain uses the inverted shift clock for the synchroniser
  assign sclkInv = ~sclk;

  // word position being driven at this falling edge
  assign edgeIdx = bitCount + 5'h01;
  assign resEnd  = wideLink ? (RESULT_IDX + 5'(RES_MAX)) : (RESULT_IDX + 5'(RES_MIN));
  assign inResult = inField(edgeIdx, RESULT_IDX, resEnd);
  // position of the result bit decided at this edge, MSB first
  assign resPos   = 4'(edgeIdx - RESULT_IDX);
  assign resBit   = 4'(RES_MAX - 1) - resPos;

  // the edge that decides the last result bit of the chosen variant
  assign lastEdge = !csN && (edgeIdx == resEnd - 5'h01);
  // running result with the bit decided at this edge already in place
  assign decided  = withBit(result, resBit, compHigh);

  // output is driven only while selected, enable low means driving
  // the pad turns a high enable into high impedance; sdoData rests at zero
  assign sdoEnN = csN;

  // sampling switch opens on the select edge and stays held for the frame
  assign holdSample = ~csN;

  // variant select crosses into the link domain
  // it must stay put while a frame runs, or that frame's word layout is undefined
  dacf_sync u_wideSync (
    .clk  (sclkInv),
    .rstN (rst_n),
    .din  (wide12),
    .dout (wideLink)
  );

  // frame edge counter, cleared by the frame's own deselect
  // a deselect before the last decision aborts the frame with no completion
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      bitCount <= '0;
    end else if (bitCount != CNT_SAT) begin
      bitCount <= edgeIdx;
    end
  end

  // channel for the coming conversion, taken from the third input bit only
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      nextChan <= CHAN_RESET;
    end else if (!csN && edgeIdx == CHAN_IDX) begin
      nextChan <= din;
    end
  end

  // select edge latches the channel and starts the conversion
  // only rst_n clears it, so a running frame never sees it move
  always_ff @(negedge csN or negedge rst_n) begin
    if (!rst_n) begin
      convChan <= CHAN_RESET;
    end else begin
      convChan <= nextChan;
    end
  end

  assign muxSel = convChan;

  // trial code: keep each decided bit and raise the next one to try
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      trial <= TRIAL_RESET;
    end else if (inResult) begin
      trial[resBit] <= compHigh;
      if (inField(edgeIdx + 5'h01, RESULT_IDX, resEnd)) begin
        trial[resBit - 4'h1] <= 1'b1;
      end
    end
  end

  assign dacCode = trial;

  // decided bits of the running conversion, one per falling edge of the result field
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      result <= RESULT_RESET;
    end else if (inResult) begin
      result[resBit] <= compHigh;
    end
  end

  // output bit for each word position, decided at the same edge it is shown
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      sdoData <= 1'b0; // first leading zero, loaded at the previous deselect
    end else if (edgeIdx == IDENT_IDX || edgeIdx == INVAL_IDX) begin
      sdoData <= convChan;
    end else if (inResult) begin
      sdoData <= compHigh;
    end else begin
      sdoData <= 1'b0; // leading and trailing zeros
    end
  end

  // copy taken at the final decision: unlike result it survives the deselect and
  // stands for a whole frame, long after the system side has read it
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      heldData <= RESULT_RESET;
      heldChan <= CHAN_RESET;
    end else if (lastEdge) begin
      heldData <= wideLink ? decided : {2'b00, decided[11:2]};
      heldChan <= convChan;
    end
  end

  // completion event toggles once the last result bit is decided
  // a toggle, not a pulse, so no event is lost whatever the clock ratio
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      doneToggle <= 1'b0;
    end else if (lastEdge) begin
      doneToggle <= ~doneToggle;
    end
  end

  // completion toggle crosses into the system domain
  // only the toggle crosses; the held word it announces is already stable
  dacf_sync u_doneSync (
    .clk  (clk_sys),
    .rstN (rst_n),
    .din  (doneToggle),
    .dout (doneSync)
  );

  // edge of the synchronised toggle
  // doneSeen trails doneSync by one cycle; a difference marks a finished frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      doneSeen <= 1'b0;
    end else begin
      doneSeen <= doneSync;
    end
  end

  // held word and channel stay frozen until the next final decision
  // so an early deselect cannot spoil the capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resultData <= RESULT_RESET;
      resultChan <= CHAN_RESET;
    end else if (doneSync != doneSeen) begin
      resultData <= heldData;
      resultChan <= heldChan;
    end
  end

  // one-cycle pulse with the captured word
  // pulse and new word appear in the same system cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resultValid <= 1'b0;
    end else begin
      resultValid <= (doneSync != doneSeen);
    end
  end
endmodule // dacf_frame

// File: dv/dacf_checker.sv
`timescale 1ns/10ps
// port-level checks for the serial frame block
module dacf_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        sclk,
  input wire logic        csN,
  input wire logic        din,
  input wire logic        sdoData,
  input wire logic        sdoEnN,
  input wire logic        compHigh,
  input wire logic        muxSel,
  input wire logic        holdSample,
  input wire logic        wide12,
  input wire logic        resultChan,
  input wire logic        resultValid,
  input wire logic [11:0] dacCode,
  input wire logic [11:0] resultData
);
  import dacf_pkg::*;
  // every check runs on the system clock, which keeps ticking between frames
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // result strobe lasts one system cycle
  sequence s_pulse;
    resultValid ##1 !resultValid;
  endsequence
  a_enable_follows_cs: assert property (sdoEnN == csN)
    else $error("enable differs from select");
  a_idle_low_out: assert property (csN |-> !sdoData)
    else $error("output busy while idle");
  a_hold_follows_cs: assert property (holdSample == !csN)
    else $error("hold not tied to select");
  a_valid_one_pulse: assert property (resultValid |-> s_pulse)
    else $error("strobe too long");
  a_data_held_between: assert property ($changed(resultData) |-> resultValid)
    else $error("data moved without strobe");
  a_chan_held_between: assert property ($changed(resultChan) |-> resultValid)
    else $error("channel moved without strobe");
  a_narrow_result: assert property (resultValid && !wide12 |-> resultData[11:10] == 2'b00)
    else $error("narrow too wide");
  a_idle_trial_mid: assert property (csN && $past(csN) |-> dacCode == TRIAL_RESET)
    else $error("trial not midscale");
  a_mux_frame_stable: assert property (!csN && !$past(csN) |-> $stable(muxSel))
    else $error("mux moved in frame");
endmodule // dacf_checker

// File: dv/dacf_host.sv
`timescale 1ns/10ps
// host side: shift clock, chip select and serial input
module dacf_host (
  output logic      sclk,
  output logic      csN,
  output logic      din,
  input  wire logic sdoData,
  input  wire logic sdoEnN
);
  initial begin
    sclk = 1'b1;
    csN = 1'b1;
    din = 1'b0;
  end
  // idle clocks with select high, lets the width setting settle
  task automatic clocks(input int n);
    repeat (n) begin
      #7.5 sclk = 1'b0;
      #7.5 sclk = 1'b1;
    end
  endtask
  // one frame of n falling edges, gap stretches the high phase
  task automatic frame(input logic [15:0] dw, input int n, input int gap,
                       output logic [15:0] word);
    word = 16'h0000;
    csN = 1'b0;
    for (int k = 0; k < n; k++) begin
      din = dw[15-k];
      #(7.5 + gap) word[15-k] = sdoEnN ? 1'bx : sdoData;
      sclk = 1'b0;
      #7.5 sclk = 1'b1;
    end
    #200 csN = 1'b1;
    din = ~din; // released line shows no stale value
  endtask
endmodule // dacf_host

// File: dv/dual_channel_adc_serial_frame_bench.sv
`timescale 1ns/10ps
// self-checking bench for the serial frame block
module dual_channel_adc_serial_frame_bench;
  import dacf_pkg::*;
  logic clk_sys, rst_n, sclk, csN, din, sdoData, sdoEnN, compHigh, muxSel;
  logic holdSample, wide12, resultChan, resultValid, gotChan, ch;
  logic [11:0] dacCode, resultData, gotData, analog;
  logic [15:0] dw, word;
  int          n_mismatch, n_compared, nValid, nBase;
  dacf_frame dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .csN(csN), .din(din),
    .sdoData(sdoData), .sdoEnN(sdoEnN), .compHigh(compHigh), .dacCode(dacCode),
    .muxSel(muxSel), .holdSample(holdSample), .wide12(wide12), .resultData(resultData),
    .resultChan(resultChan), .resultValid(resultValid));
  dacf_host host (.sclk(sclk), .csN(csN), .din(din), .sdoData(sdoData), .sdoEnN(sdoEnN));
  assign compHigh = (analog >= dacCode); // comparator model
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // capture each delivered result
  always @(posedge clk_sys) if (resultValid === 1'b1) begin
    gotData <= resultData;
    gotChan <= resultChan;
    nValid <= nValid + 1;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] expWord(input logic c, input logic [11:0] a, input logic w);
    return w ? {2'b00, c, c, a} : {2'b00, c, c, a[11:2], 2'b00};
  endfunction
  // random frames at one width, zero and full scale first
  task automatic run(input logic w, input int frames);
    wide12 = w;
    host.clocks(3);
    for (int i = 0; i < frames; i++) begin
      @(posedge clk_sys) #2;
      analog = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
      dw = 16'($urandom);
      nBase = nValid;
      // frame 3 runs the shift clock at full rate: 7.5 ns low, 192.5 ns high
      host.frame(dw, (w || i % 2) ? 16 : 14, (i == 3) ? 185 : (i % 2) * 20, word);
      check(word, expWord(ch, analog, w));
      check({4'(nValid - nBase), gotData}, {4'h1, w ? analog : {2'b00, analog[11:2]}});
      check({15'h0, gotChan}, {15'h0, ch});
      check({15'h0, muxSel}, {15'h0, ch});
      ch = dw[13];
    end
    $display("test done: width %0d", w ? 12 : 10);
  endtask
  task automatic stop_test;
    $display("counts: %0d compared, %0d wrong", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #60000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    void'($urandom(79899));
    rst_n = 1'b0;
    wide12 = 1'b1;
    analog = 12'h000;
    ch = CHAN_RESET;
    host.clocks(4);
    repeat (12) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    run(1'b1, 6);
    @(posedge clk_sys) #2;
    dw = 16'($urandom);
    nBase = nValid;
    host.frame(dw, 8, 0, word);
    check(16'(nValid - nBase), 16'h0000);
    check(word & 16'hFF00, expWord(ch, analog, 1'b1) & 16'hFF00);
    check({15'h0, sdoEnN}, 16'h0001);
    ch = dw[13];
    $display("test done: abort");
    run(1'b0, 6);
    stop_test;
  end
endmodule // dual_channel_adc_serial_frame_bench
bind dacf_frame dacf_checker chk (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .csN(csN),
  .din(din), .sdoData(sdoData), .sdoEnN(sdoEnN), .compHigh(compHigh), .muxSel(muxSel),
  .holdSample(holdSample), .wide12(wide12), .resultChan(resultChan),
  .resultValid(resultValid), .dacCode(dacCode), .resultData(resultData));
